// ### rtl/bss_boot_selector.sv
// Purpose: reset-time page 0 check and choice of boot image and address layout
// Assumes: flash read port answers each held request with one ack pulse;
//   signature engine answers a held request with one done pulse and its result
// Notes:
// Notes on behaviour
// - checksum word all ones after reset means no page 0 signature.
// - otherwise sign 0x00000 to 0x01FFB and compare with stored checksum.
// - matching signature lets the user image start.
// - mismatching signature blocks the user image and selects downloader mode.
// - reset-time signature never covers more than page 0.
// - signature result compared with checksum at 0x1FFC of page 0.
// - full user space signing takes about 128k flash clocks, 8.192 ms.
// - one 72-bit write typically 46 us at 16 MHz, guidance only.
// - fast sequential writes within a page typically 20 us each.
// - flash operation in fetch block stalls instruction fetch until done.
// - unswitched layout puts block 0 low, block 1 high.
// - switched layout puts block 1 low, block 0 high.
// - six modes, entered only through reset, chosen from key values.
// - revision key at 0x7FFC0 holds update number, higher is newer.
// - trial key reads erased after download; passed code sets it zero.
// - read both blocks' revision and trial keys before remapping.
// - download-select high at reset gives debug mode, user image runs.
// - prefer larger revision key; fall back when its trial key nonzero.
// - no trial key at zero means downloader mode.
// - swap bit 3 of user setup register switches mapping in trial.
`timescale 1ns/1ps
`include "bss_params.svh"

module bss_boot_selector
  import bss_pkg::*;
#(
  parameter int ADDR_W = `BSS_ADDR_W,
  parameter int SIGN_TIMEOUT_CYCLES = `BSS_SIGN_FULL_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic download_select_in,
  output logic rd_req_out,
  output logic [ADDR_W-1:0] rd_addr_out,
  input wire logic rd_ack_in,
  input wire logic [`BSS_WORD_W-1:0] rd_data_in,
  output logic sign_req_out,
  output logic [ADDR_W-1:0] sign_first_addr_out,
  output logic [ADDR_W-1:0] sign_last_addr_out,
  input wire logic sign_done_in,
  input wire logic [`BSS_WORD_W-1:0] sign_result_in,
  input wire logic [`BSS_WORD_W-1:0] flash_user_setup_reg_in,
  input wire logic flash_op_busy_in,
  input wire logic flash_op_block_in,
  input wire logic fetch_addr_high_in,
  output logic [2:0] mode_out,
  output logic layout_switched_out,
  output logic user_fetch_en_out,
  output logic fetch_stall_out,
  output logic sign_timeout_out
);

  if (ADDR_W != `BSS_ADDR_W) begin : g_bad_addr
    $error("bss_boot_selector: ADDR_W must match the flash address width");
  end
  if (SIGN_TIMEOUT_CYCLES < 1 || SIGN_TIMEOUT_CYCLES >= (1 << `BSS_TIMER_W)) begin : g_bad_to
    $error("bss_boot_selector: SIGN_TIMEOUT_CYCLES out of timer range");
  end

  localparam logic [`BSS_TIMER_W-1:0] SIGN_LIMIT = `BSS_TIMER_W'(SIGN_TIMEOUT_CYCLES);
  localparam logic [`BSS_IDX_W-1:0] LAST_SLOT = `BSS_SLOT_TRIAL1;

  bss_regs_t r;
  bss_regs_t next_r;

  logic mem_we;
  logic [`BSS_IDX_W-1:0] mem_rd_idx;
  logic [`BSS_WORD_W-1:0] mem_rd_data;

  // reads land in the store, then come back one at a time for the decision
  bss_key_mem #(
    .DATA_W(`BSS_WORD_W),
    .DEPTH(`BSS_NUM_WORDS),
    .IDX_W(`BSS_IDX_W)
  ) u_key_mem (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(mem_we),
    .wr_idx_in(r.idx),
    .wr_data_in(rd_data_in),
    .rd_idx_in(mem_rd_idx),
    .rd_data_out(mem_rd_data)
  );

  // flash address of each stored word
  function automatic logic [ADDR_W-1:0] slot_addr(input logic [`BSS_IDX_W-1:0] idx);
    logic [ADDR_W-1:0] a;
    a = `BSS_PAGE0_CSUM_ADDR;
    case (idx)
      `BSS_SLOT_CSUM: a = `BSS_PAGE0_CSUM_ADDR;
      `BSS_SLOT_REV0: a = `BSS_BLOCK0_REV_KEY_ADDR;
      `BSS_SLOT_TRIAL0: a = `BSS_BLOCK0_TRIAL_KEY_ADDR;
      `BSS_SLOT_REV1: a = `BSS_BLOCK1_REV_KEY_ADDR;
      `BSS_SLOT_TRIAL1: a = `BSS_BLOCK1_TRIAL_KEY_ADDR;
      default: a = `BSS_PAGE0_CSUM_ADDR;
    endcase
    return a;
  endfunction

  // erased revision key ranks below every programmed one
  function automatic logic signed [`BSS_WORD_W:0] rev_rank(input logic [`BSS_WORD_W-1:0] k);
    logic signed [`BSS_WORD_W:0] v;
    v = $signed({1'b0, k});
    if (k == `BSS_ERASED) begin
      v = -33'sd1;
    end
    return v;
  endfunction

  logic signed [`BSS_WORD_W:0] rank0;
  logic signed [`BSS_WORD_W:0] rank1;
  logic prefer_b;
  logic pref_trial_ok;
  logic other_trial_ok;
  logic in_trial;
  logic swap_bit;
  logic fetch_block;

  always_comb begin
    rank0 = rev_rank(r.rev0);
    rank1 = rev_rank(r.rev1);
    // ties go to block 0, so block 1 never wins without a strictly newer key
    prefer_b = (rank1 > rank0);
    pref_trial_ok = prefer_b ? (r.trial1 == `BSS_TRIAL_PASSED) : (r.trial0 == `BSS_TRIAL_PASSED);
    other_trial_ok = prefer_b ? (r.trial0 == `BSS_TRIAL_PASSED) : (r.trial1 == `BSS_TRIAL_PASSED);
    in_trial = (r.mode == BSS_MODE_TRIAL_A) || (r.mode == BSS_MODE_TRIAL_B);
    swap_bit = flash_user_setup_reg_in[`BSS_SWAP_BIT];
    // physical block behind the fetch address under the current layout
    fetch_block = fetch_addr_high_in ^ r.switched;
  end

  always_comb begin
    next_r = r;
    mem_we = 1'b0;
    mem_rd_idx = r.idx;
    next_r.timeout = 1'b0;
    case (r.state)
      BSS_ST_STRAP: begin
        // strap sampled by the clock after reset release, never by the reset itself
        if (download_select_in) begin
          next_r.mode = BSS_MODE_DEBUG;
          next_r.switched = 1'b0;
          next_r.state = BSS_ST_RUN;
        end else begin
          next_r.idx = `BSS_SLOT_CSUM;
          next_r.rd_addr = slot_addr(`BSS_SLOT_CSUM);
          next_r.rd_req = 1'b1;
          next_r.state = BSS_ST_READ;
        end
      end
      BSS_ST_READ: begin
        if (rd_ack_in) begin
          mem_we = 1'b1;
          if (r.idx == LAST_SLOT) begin
            next_r.rd_req = 1'b0;
            next_r.idx = `BSS_SLOT_CSUM;
            next_r.state = BSS_ST_RECALL;
          end else begin
            next_r.idx = r.idx + `BSS_IDX_W'(1);
            next_r.rd_addr = slot_addr(r.idx + `BSS_IDX_W'(1));
          end
        end
      end
      BSS_ST_RECALL: begin
        // store answers one cycle late, so each word lands under the previous index
        if (r.idx != `BSS_SLOT_CSUM) begin
          case (r.idx - `BSS_IDX_W'(1))
            `BSS_SLOT_CSUM: next_r.csum = mem_rd_data;
            `BSS_SLOT_REV0: next_r.rev0 = mem_rd_data;
            `BSS_SLOT_TRIAL0: next_r.trial0 = mem_rd_data;
            `BSS_SLOT_REV1: next_r.rev1 = mem_rd_data;
            default: next_r.trial1 = mem_rd_data;
          endcase
        end
        if (r.idx == LAST_SLOT + `BSS_IDX_W'(1)) begin
          next_r.state = BSS_ST_CHECK;
        end else begin
          next_r.idx = r.idx + `BSS_IDX_W'(1);
        end
      end
      BSS_ST_CHECK: begin
        if (r.csum == `BSS_ERASED) begin
          next_r.state = BSS_ST_DECIDE;
        end else begin
          next_r.sign_req = 1'b1;
          next_r.timer = '0;
          next_r.state = BSS_ST_SIGN;
        end
      end
      BSS_ST_SIGN: begin
        next_r.timer = r.timer + `BSS_TIMER_W'(1);
        if (sign_done_in) begin
          next_r.sign_req = 1'b0;
          // result checked against the word just above the signed range
          if (sign_result_in == r.csum) begin
            next_r.state = BSS_ST_DECIDE;
          end else begin
            next_r.mode = BSS_MODE_DOWNLOADER;
            next_r.switched = 1'b0;
            next_r.state = BSS_ST_RUN;
          end
        end else if (r.timer == SIGN_LIMIT - `BSS_TIMER_W'(1)) begin
          // a hung engine would hold the part in reset forever; the bound is a
          // full user space signature, far longer than page 0 needs
          next_r.sign_req = 1'b0;
          next_r.timeout = 1'b1;
          next_r.mode = BSS_MODE_DOWNLOADER;
          next_r.switched = 1'b0;
          next_r.state = BSS_ST_RUN;
        end
      end
      BSS_ST_DECIDE: begin
        // mode and layout settle here; fetch opens one cycle later
        next_r.state = BSS_ST_RUN;
        if (pref_trial_ok) begin
          next_r.mode = prefer_b ? BSS_MODE_NORMAL_B : BSS_MODE_NORMAL_A;
          next_r.switched = prefer_b;
        end else if (other_trial_ok) begin
          // older image runs the trial on the newer one
          next_r.mode = prefer_b ? BSS_MODE_TRIAL_A : BSS_MODE_TRIAL_B;
          next_r.switched = !prefer_b;
        end else begin
          next_r.mode = BSS_MODE_DOWNLOADER;
          next_r.switched = 1'b0;
        end
      end
      BSS_ST_RUN: begin
        // user images and debug fetch; downloader mode keeps the user image shut
        next_r.user_fetch = (r.mode != BSS_MODE_DOWNLOADER);
        // swap bit flips the layout only while a trial runs
        if (in_trial) begin
          next_r.switched = (r.mode == BSS_MODE_TRIAL_B) ^ swap_bit;
        end
      end
      default: begin
        next_r.state = BSS_ST_STRAP;
      end
    endcase
    // fetch held while the boot decision runs or a flash operation owns its block;
    // write and erase times vary, so the hold follows busy, never a fixed count
    next_r.stall = !next_r.user_fetch ||
                   (flash_op_busy_in && (flash_op_block_in == fetch_block));
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r.state <= BSS_ST_STRAP;
      r.idx <= '0;
      r.csum <= `BSS_ERASED;
      r.rev0 <= `BSS_ERASED;
      r.trial0 <= `BSS_ERASED;
      r.rev1 <= `BSS_ERASED;
      r.trial1 <= `BSS_ERASED;
      r.timer <= '0;
      r.mode <= BSS_MODE_BOOTING;
      r.rd_req <= 1'b0;
      r.rd_addr <= '0;
      r.sign_req <= 1'b0;
      r.switched <= 1'b0;
      r.user_fetch <= 1'b0;
      r.stall <= 1'b1;
      r.timeout <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // sticky report of a signature that never answered
  logic timeout_seen;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timeout_seen <= 1'b0;
    end else if (r.timeout) begin
      timeout_seen <= 1'b1;
    end
  end

  // sign range is fixed to page 0, so a constant range drives the engine
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sign_first_addr_out <= '0;
      sign_last_addr_out <= '0;
    end else begin
      sign_first_addr_out <= `BSS_PAGE0_FIRST_ADDR;
      sign_last_addr_out <= `BSS_PAGE0_LAST_ADDR;
    end
  end

  assign rd_req_out = r.rd_req;
  assign rd_addr_out = r.rd_addr;
  assign sign_req_out = r.sign_req;
  assign mode_out = r.mode;
  assign layout_switched_out = r.switched;
  assign user_fetch_en_out = r.user_fetch;
  assign fetch_stall_out = r.stall;
  assign sign_timeout_out = timeout_seen;

endmodule

// ### common/bss_params.svh
// Purpose: constants of the dual image boot selector
// Assumes: 20 MHz system clock, 20-bit flash byte addresses
// Notes: definitions only
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH

`define BSS_ADDR_W 20
`define BSS_WORD_W 32
`define BSS_NUM_WORDS 5
`define BSS_IDX_W 3

// word slots in the key store, also the order of reset-time reads
`define BSS_SLOT_CSUM 3'h0
`define BSS_SLOT_REV0 3'h1
`define BSS_SLOT_TRIAL0 3'h2
`define BSS_SLOT_REV1 3'h3
`define BSS_SLOT_TRIAL1 3'h4

// page 0 layout; the user image keeps the top word free for the checksum
`define BSS_PAGE0_FIRST_ADDR 20'h00000
`define BSS_PAGE0_LAST_ADDR 20'h01FFB
`define BSS_PAGE0_CSUM_ADDR 20'h01FFC
`define BSS_PAGE0_TOP_ADDR 20'h01FFF

// key words, as seen before any remapping
`define BSS_BLOCK0_REV_KEY_ADDR 20'h7FFC0
`define BSS_BLOCK0_TRIAL_KEY_ADDR 20'h7FFC8
`define BSS_BLOCK1_REV_KEY_ADDR 20'hFFFC0
`define BSS_BLOCK1_TRIAL_KEY_ADDR 20'hFFFC8
// optional whole-space crc words, never read by the selector
`define BSS_BLOCK0_CRC_ADDR 20'h7FFFC
`define BSS_BLOCK1_CRC_ADDR 20'hFFFFC

// address map halves
`define BSS_LOW_FIRST_ADDR 20'h00000
`define BSS_LOW_LAST_ADDR 20'h7FFFF
`define BSS_HIGH_FIRST_ADDR 20'h80000
`define BSS_HIGH_LAST_ADDR 20'hFFFFF
`define BSS_BLOCK_SEL_BIT 19

`define BSS_ERASED 32'hFFFFFFFF
`define BSS_TRIAL_PASSED 32'h00000000
`define BSS_SWAP_BIT 3

// timing, clock rate in MHz and times in us
`define BSS_CLK_MHZ 20
`define BSS_SIGN_FULL_FLASH_CYCLES 131072
`define BSS_SIGN_FULL_US 8192
`define BSS_SIGN_FULL_CYCLES (`BSS_SIGN_FULL_US * `BSS_CLK_MHZ)
`define BSS_WRITE_TYP_US 46
`define BSS_WRITE_TYP_CYCLES (`BSS_WRITE_TYP_US * `BSS_CLK_MHZ)
`define BSS_FAST_WRITE_TYP_US 20
`define BSS_FAST_WRITE_TYP_CYCLES (`BSS_FAST_WRITE_TYP_US * `BSS_CLK_MHZ)
`define BSS_TIMER_W 18

`endif

// ### common/bss_pkg.sv
// Purpose: types of the dual image boot selector
// Assumes: bss_params.svh for widths
// Notes: mode codes leave the block on mode_out
`include "bss_params.svh"

package bss_pkg;

  typedef enum logic [2:0] {
    BSS_MODE_BOOTING = 3'h0,
    BSS_MODE_DEBUG = 3'h1,
    BSS_MODE_DOWNLOADER = 3'h2,
    BSS_MODE_NORMAL_A = 3'h3,
    BSS_MODE_TRIAL_A = 3'h4,
    BSS_MODE_NORMAL_B = 3'h5,
    BSS_MODE_TRIAL_B = 3'h6
  } bss_mode_t;

  typedef enum logic [2:0] {
    BSS_ST_STRAP = 3'h0,
    BSS_ST_READ = 3'h1,
    BSS_ST_RECALL = 3'h2,
    BSS_ST_CHECK = 3'h3,
    BSS_ST_SIGN = 3'h4,
    BSS_ST_DECIDE = 3'h5,
    BSS_ST_RUN = 3'h6
  } bss_state_t;

  typedef struct packed {
    bss_state_t state;
    logic [`BSS_IDX_W-1:0] idx;
    logic [`BSS_WORD_W-1:0] csum;
    logic [`BSS_WORD_W-1:0] rev0;
    logic [`BSS_WORD_W-1:0] trial0;
    logic [`BSS_WORD_W-1:0] rev1;
    logic [`BSS_WORD_W-1:0] trial1;
    logic [`BSS_TIMER_W-1:0] timer;
    bss_mode_t mode;
    logic rd_req;
    logic [`BSS_ADDR_W-1:0] rd_addr;
    logic sign_req;
    logic switched;
    logic user_fetch;
    logic stall;
    logic timeout;
  } bss_regs_t;

endpackage

// ### rtl/bss_key_mem.sv
// Purpose: small word store for key and checksum words
// Assumes: one write and one read port, same clock
// Notes: read data come out of a register, one cycle after the address
`timescale 1ns/1ps
`include "bss_params.svh"

module bss_key_mem #(
  parameter int DATA_W = `BSS_WORD_W,
  parameter int DEPTH = `BSS_NUM_WORDS,
  parameter int IDX_W = `BSS_IDX_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [IDX_W-1:0] wr_idx_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic [IDX_W-1:0] rd_idx_in,
  output logic [DATA_W-1:0] rd_data_out
);

  logic [DATA_W-1:0] mem [DEPTH];

  if (DEPTH > (1 << IDX_W)) begin : g_bad_depth
    $error("bss_key_mem: DEPTH does not fit IDX_W");
  end

  // one storage word per entry; words carry no reset, they are always written first
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge sys_clk_in) begin
      if (wr_en_in && (wr_idx_in == IDX_W'(i))) begin
        mem[i] <= wr_data_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else if (int'(rd_idx_in) < DEPTH) begin
      rd_data_out <= mem[rd_idx_in];
    end else begin
      rd_data_out <= '0;
    end
  end

endmodule

// ### verif/bss_flash_model.sv
// Purpose: flash array and signature engine facing the boot selector
// Assumes: bench sets word, sig, lat and mute while reset is held
// Notes: idle data lines toggle so a stale word never passes for an answer
`timescale 1ns/1ps
`include "bss_params.svh"
module bss_flash_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic rd_req_in,
  input wire logic [19:0] rd_addr_in,
  input wire logic sign_req_in,
  output logic rd_ack_out,
  output logic [31:0] rd_data_out,
  output logic sign_done_out,
  output logic [31:0] sign_result_out
);
  // keys are only read here, nothing is programmed twice
  logic [31:0] word [5];
  logic [31:0] sig;
  int lat;
  int cnt;
  int signs;
  bit mute;
  logic sr_q;
  // page 0 top word holds the checksum; crc words are never offered
  function automatic logic [31:0] pick(logic [19:0] a);
    case (a)
      `BSS_PAGE0_CSUM_ADDR: return word[0];
      `BSS_BLOCK0_REV_KEY_ADDR: return word[1];
      `BSS_BLOCK0_TRIAL_KEY_ADDR: return word[2];
      `BSS_BLOCK1_REV_KEY_ADDR: return word[3];
      `BSS_BLOCK1_TRIAL_KEY_ADDR: return word[4];
      default: return 32'hDEADBEEF;
    endcase
  endfunction
  // end of work is told only by an ack pulse for a read or a done pulse for a signature
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_ack_out <= 1'b0;
      sign_done_out <= 1'b0;
      rd_data_out <= 32'h5A5A5A5A;
      sign_result_out <= 32'hA5A5A5A5;
      cnt <= 0;
      signs <= 0;
      sr_q <= 1'b0;
    end else begin
      rd_ack_out <= 1'b0;
      sign_done_out <= 1'b0;
      rd_data_out <= ~rd_data_out;
      sign_result_out <= ~sign_result_out;
      sr_q <= sign_req_in;
      if (sign_req_in && !sr_q) begin
        signs <= signs + 1;
      end
      if ((rd_req_in && !rd_ack_out) || (sign_req_in && !sign_done_out && !mute)) begin
        cnt <= cnt + 1;
        if (cnt >= lat) begin
          cnt <= 0;
          rd_ack_out <= rd_req_in;
          sign_done_out <= !rd_req_in;
          rd_data_out <= rd_req_in ? pick(rd_addr_in) : ~rd_data_out;
          sign_result_out <= rd_req_in ? ~sign_result_out : sig;
        end
      end
    end
  end
endmodule

// ### verif/bss_boot_selector_chk.sv
// Purpose: port checks of the boot selector
// Assumes: one clock domain, reset active low
// Notes: stored checksum is captured from the read port itself
`timescale 1ns/1ps
`include "bss_params.svh"
module bss_boot_selector_chk
  import bss_pkg::*;
#(
  parameter int ADDR_W = `BSS_ADDR_W,
  parameter int SIGN_TIMEOUT_CYCLES = `BSS_SIGN_FULL_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic rd_req_out,
  input wire logic [ADDR_W-1:0] rd_addr_out,
  input wire logic rd_ack_in,
  input wire logic [`BSS_WORD_W-1:0] rd_data_in,
  input wire logic sign_req_out,
  input wire logic [ADDR_W-1:0] sign_first_addr_out,
  input wire logic [ADDR_W-1:0] sign_last_addr_out,
  input wire logic sign_done_in,
  input wire logic [`BSS_WORD_W-1:0] sign_result_in,
  input wire logic [`BSS_WORD_W-1:0] flash_user_setup_reg_in,
  input wire logic flash_op_busy_in,
  input wire logic flash_op_block_in,
  input wire logic fetch_addr_high_in,
  input wire logic [2:0] mode_out,
  input wire logic layout_switched_out,
  input wire logic user_fetch_en_out,
  input wire logic fetch_stall_out
);
  logic [31:0] csum_q;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      csum_q <= `BSS_ERASED;
    end else if (rd_req_out && rd_ack_in && rd_addr_out == `BSS_PAGE0_CSUM_ADDR) begin
      csum_q <= rd_data_in;
    end
  end
  AST_RD_HOLD: assert property (
    rd_req_out && !rd_ack_in |=> rd_req_out && $stable(rd_addr_out)) else $error("read moved");
  AST_RD_ADDR: assert property (rd_req_out |-> rd_addr_out inside {
    `BSS_PAGE0_CSUM_ADDR, `BSS_BLOCK0_REV_KEY_ADDR, `BSS_BLOCK0_TRIAL_KEY_ADDR,
    `BSS_BLOCK1_REV_KEY_ADDR, `BSS_BLOCK1_TRIAL_KEY_ADDR}) else $error("stray read");
  AST_SIGN_RANGE: assert property (sign_req_out |-> sign_first_addr_out == 20'h00000
    && sign_last_addr_out == 20'h01FFB) else $error("signature range wrong");
  AST_NO_SIGN_ERASED: assert property (
    $rose(sign_req_out) |-> csum_q != `BSS_ERASED) else $error("signed with no checksum");
  AST_SIGN_BAD: assert property (sign_req_out && sign_done_in && sign_result_in != csum_q
    |-> ##[1:3] mode_out == BSS_MODE_DOWNLOADER) else $error("bad page 0 not refused");
  AST_FETCH_MODE: assert property ($rose(user_fetch_en_out) |->
    $past(mode_out) != BSS_MODE_BOOTING && $stable(mode_out)) else $error("fetch before mode");
  AST_DL_NO_FETCH: assert property (
    mode_out == BSS_MODE_DOWNLOADER |-> !user_fetch_en_out) else $error("downloader fetches");
  AST_MODE_HOLD: assert property (
    mode_out != BSS_MODE_BOOTING |=> $stable(mode_out)) else $error("mode changed");
  AST_LAYOUT: assert property (mode_out inside {1, 2, 3, 5} |->
    layout_switched_out == (mode_out == BSS_MODE_NORMAL_B)) else $error("layout wrong");
  AST_SWAP: assert property ((mode_out == 4 || mode_out == 6) && $stable(mode_out)
    |-> layout_switched_out == ($past(flash_user_setup_reg_in[3]) ^ (mode_out == 6)))
    else $error("swap bit ignored");
  AST_STALL: assert property (fetch_stall_out == (!user_fetch_en_out ||
    ($past(flash_op_busy_in) && ($past(flash_op_block_in) ==
    ($past(fetch_addr_high_in) ^ $past(layout_switched_out)))))) else $error("stall wrong");
endmodule
bind bss_boot_selector bss_boot_selector_chk #(.ADDR_W(ADDR_W),
  .SIGN_TIMEOUT_CYCLES(SIGN_TIMEOUT_CYCLES)) u_chk (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .rd_req_out(rd_req_out), .rd_addr_out(rd_addr_out),
  .rd_ack_in(rd_ack_in), .rd_data_in(rd_data_in), .sign_req_out(sign_req_out),
  .sign_first_addr_out(sign_first_addr_out), .sign_last_addr_out(sign_last_addr_out),
  .sign_done_in(sign_done_in), .sign_result_in(sign_result_in),
  .flash_user_setup_reg_in(flash_user_setup_reg_in), .flash_op_busy_in(flash_op_busy_in),
  .flash_op_block_in(flash_op_block_in), .fetch_addr_high_in(fetch_addr_high_in),
  .mode_out(mode_out), .layout_switched_out(layout_switched_out),
  .user_fetch_en_out(user_fetch_en_out), .fetch_stall_out(fetch_stall_out));

// ### verif/dual_image_boot_selector_tb.sv
// Purpose: self-checking bench of the boot selector
// Assumes: short signature timeout so a mute engine ends a boot quickly
// Notes: every boot begins with a reset, since modes change only there
`timescale 1ns/1ps
`include "bss_params.svh"
module dual_image_boot_selector_tb;
  localparam logic [31:0] E = `BSS_ERASED;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic busy = 1'b0;
  logic blk = 1'b0;
  logic high = 1'b0;
  logic [31:0] setup = 32'h0;
  logic rd_req, rd_ack, sreq, sdone, sw, fe, stall, tmo;
  logic [19:0] addr, sfirst, slast;
  logic [31:0] rdata, sres, sg;
  logic [2:0] mode;
  logic [31:0] w [5];
  bit mute;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  always #25 clk = ~clk;
  bss_boot_selector #(.SIGN_TIMEOUT_CYCLES(64)) DUT (
    .sys_clk_in(clk), .rst_n_in(rst_n), .download_select_in(strap),
    .rd_req_out(rd_req), .rd_addr_out(addr), .rd_ack_in(rd_ack), .rd_data_in(rdata),
    .sign_req_out(sreq), .sign_first_addr_out(sfirst), .sign_last_addr_out(slast),
    .sign_done_in(sdone), .sign_result_in(sres), .flash_user_setup_reg_in(setup),
    .flash_op_busy_in(busy), .flash_op_block_in(blk), .fetch_addr_high_in(high),
    .mode_out(mode), .layout_switched_out(sw), .user_fetch_en_out(fe),
    .fetch_stall_out(stall), .sign_timeout_out(tmo));
  bss_flash_model flash (
    .clk_in(clk), .rst_n_in(rst_n), .rd_req_in(rd_req), .rd_addr_in(addr),
    .sign_req_in(sreq), .rd_ack_out(rd_ack), .rd_data_out(rdata),
    .sign_done_out(sdone), .sign_result_out(sres));
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // erased revision keys rank as minus one; a tie keeps block 0
  function automatic int ref_mode();
    longint r0;
    longint r1;
    bit pb;
    r0 = (w[1] === E) ? -1 : longint'(w[1]);
    r1 = (w[3] === E) ? -1 : longint'(w[3]);
    pb = r1 > r0;
    if (strap) return 1;
    if (w[0] !== E && (mute || sg !== w[0])) return 2;
    if ((pb ? w[4] : w[2]) === 0) return pb ? 5 : 3;
    if ((pb ? w[2] : w[4]) === 0) return pb ? 4 : 6;
    return 2;
  endfunction
  function automatic logic exp_sw(int m);
    if (m == 5) return 1'b1;
    if (m == 4 || m == 6) return setup[3] ^ (m == 6);
    return 1'b0;
  endfunction
  function automatic logic [31:0] rk();
    return ($urandom % 3 == 0) ? E : 32'($urandom % 4);
  endfunction
  task automatic run(bit st, logic [31:0] cs, r0, t0, r1, t1, bit good, mu, s3, string nm);
    int m;
    int k;
    logic e;
    @(negedge clk);
    rst_n = 1'b0;
    strap = st;
    w = '{cs, r0, t0, r1, t1};
    sg = good ? cs : ~cs;
    mute = mu;
    setup = $urandom;
    setup[3] = s3;
    flash.word = w;
    flash.sig = sg;
    flash.mute = mu;
    flash.lat = $urandom % 4;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    for (k = 0; k < 300 && mode === 3'h0; k++) @(negedge clk);
    repeat (4) @(negedge clk);
    m = ref_mode();
    check("mode", m, mode);
    check("switched", exp_sw(m), sw);
    check("fetch", m != 2, fe);
    check("signs", !st && cs !== E, flash.signs);
    check("sign_last", `BSS_PAGE0_LAST_ADDR, slast);
    check("timeout", !st && cs !== E && mu, tmo);
    for (k = 0; k < 6; k++) begin
      {busy, blk, high} = 3'($urandom);
      e = !fe || (busy && (blk == (high ^ sw)));
      @(negedge clk);
      check("stall", e, stall);
    end
    setup[3] = !s3;
    repeat (2) @(negedge clk);
    check("swap", exp_sw(m), sw);
    $display("test %s done", nm);
  endtask
  initial begin
    void'($urandom(32'h9E1A));
    run(1, 32'h1234, 0, 5, 0, 5, 0, 0, 0, "debug");
    run(0, E, E, E, E, E, 0, 0, 0, "blank");
    run(0, E, 1, 0, E, E, 0, 0, 0, "normal_a");
    run(0, E, 0, 0, E, 0, 0, 0, 1, "erased_rank");
    run(0, E, 1, 0, 2, E, 0, 0, 1, "trial_a");
    run(0, E, 1, 0, 2, 0, 0, 0, 0, "normal_b");
    run(0, E, 3, E, 2, 0, 0, 0, 0, "trial_b");
    run(0, E, 2, 0, 2, 0, 0, 0, 0, "tie");
    run(0, 32'h00ABCDEF, 1, 0, E, E, 1, 0, 0, "sum_ok");
    run(0, 32'h00ABCDEF, 1, 0, E, E, 0, 0, 0, "sum_bad");
    run(0, 32'h00000001, 1, 0, 2, 0, 1, 1, 0, "sign_mute");
    for (n = 0; n < 24; n++) begin
      run($urandom % 8 == 0, ($urandom % 2) ? E : $urandom, rk(), rk(), rk(), rk(),
        1'($urandom), $urandom % 4 == 0, 1'($urandom), "random");
    end
    conclude();
  end
endmodule
